// >>> cmbi_top.v
// configurable host bus front end: strobes, latches, decoder, ports
`timescale 1ns/10ps
`include "cmbi_map.vh"
// How it works
// - width select 0 gives a byte-wide host data path.
// - mux select 1 multiplexes address/data, 0 keeps them separate.
// - strobe style 0 uses read/write strobes, 1 uses direction plus enable.
// - top pin select 0 makes power-down input, 1 makes address bit 19.
// - the top pin is always an input.
// - latch polarity 0 makes the address latch strobe active high.
// - reset polarity 1 means active-high reset pin, 0 active low.
// - split 1 uses program store enable to separate code and data.
// - port a track 0 and field 00 make all port a lines i/o.
// - port b field ff makes i/o, 00 makes chip-select outputs.
// - port c field 000 inputs, 111 chip selects, 100 top only output.
// - driver type bit 1 gives open drain, 0 push-pull.
// - upper latch select 0 passes upper address transparently.
// - readback lock refuses configuration readback by programmers.
// - with lock set, normal host reads still return data.
// - power-down also silences the decoder; one device must stay awake.
// - decoder chip selects follow address ranges to wake other devices.
// - in separate mode the latch strobe is a general decoder input.
// - width select 1 gives a 16-bit host data path.
// - power-down input high puts the device in standby.
// - reset makes all i/o port lines inputs until directions are written.
module cmbi_top #(
  parameter DW = 16
) (
  input  wire          CLK,
  input  wire          RSTN,
  input  wire          CFG_DATA_WIDTH_SEL,
  input  wire          CFG_ADDR_DATA_MUX_SEL,
  input  wire          CFG_STROBE_STYLE_SEL,
  input  wire          CFG_TOP_PIN_FUNCTION_SEL,
  input  wire          CFG_LATCH_STROBE_POLARITY,
  input  wire          CFG_RESET_POLARITY_SEL,
  input  wire          CFG_CODE_DATA_SPLIT_SEL,
  input  wire          CFG_PORTA_TRACK_SEL,
  input  wire [7:0]    CFG_PORTA_BIT_FUNCTION,
  input  wire [7:0]    CFG_PORTB_BIT_FUNCTION,
  input  wire [2:0]    CFG_PORTC_BIT_FUNCTION,
  input  wire [7:0]    CFG_PORTA_DRIVER_TYPE,
  input  wire [7:0]    CFG_PORTB_DRIVER_TYPE,
  input  wire          CFG_UPPER_ADDR_LATCH_SEL,
  input  wire          CFG_READBACK_LOCK,
  input  wire          HOST_RESET,
  input  wire          RD_N,
  input  wire          WR_N,
  input  wire          RW,
  input  wire          E,
  input  wire          ALE,
  input  wire          PROGRAM_STORE_ENABLE_N,
  input  wire          TOP_PIN,
  input  wire [15:0]   ADDR_I,
  input  wire [DW-1:0] HD_I,
  output reg  [DW-1:0] HD_O,
  output reg  [1:0]    HD_OE,
  input  wire [7:0]    PA_I,
  output reg  [7:0]    PA_O,
  output reg  [7:0]    PA_OE,
  input  wire [7:0]    PB_I,
  output reg  [7:0]    PB_O,
  output reg  [7:0]    PB_OE,
  input  wire [2:0]    PC_I,
  output reg  [2:0]    PC_O,
  output reg  [2:0]    PC_OE,
  input  wire [DW-1:0] MEM_RDATA,
  output reg  [19:0]   MEM_ADDR,
  output reg           MEM_CODE_SEL,
  output reg           MEM_DATA_SEL,
  output reg           MEM_RD,
  output reg           MEM_WR,
  output reg  [DW-1:0] MEM_WDATA,
  output reg           POWER_DOWN,
  input  wire          PROG_RD_REQ,
  input  wire [1:0]    PROG_RD_SEL,
  output reg  [7:0]    PROG_RD_DATA,
  output reg           PROG_RD_DENIED
);

  // filtered pin value: moves only when stages two and three agree
  function [`CMBI_P_W-1:0] agree;
    input [`CMBI_P_W-1:0] s2;
    input [`CMBI_P_W-1:0] s3;
    input [`CMBI_P_W-1:0] old;
    begin
      agree = (s2 & s3) | (old & (s2 ^ s3));
    end
  endfunction

  // decoder term: one 64k region of the 20-bit space per select
  function hit;
    input [19:0] a;
    input [3:0]  idx;
    begin
      hit = (a[19:16] == idx);
    end
  endfunction

  // open-drain drives only a low; push-pull drives whenever enabled
  function [7:0] drv_en;
    input [7:0] en;
    input [7:0] val;
    input [7:0] od;
    begin
      drv_en = en & (~od | ~val);
    end
  endfunction

  wire [`CMBI_P_W-1:0] pins = {PB_I, PA_I, HD_I[15:0], ADDR_I, PC_I,
                               TOP_PIN, HOST_RESET, PROGRAM_STORE_ENABLE_N,
                               ALE, E, RW, WR_N, RD_N};

  reg  [`CMBI_P_W-1:0] s1_q;
  reg  [`CMBI_P_W-1:0] s2_q;
  reg  [`CMBI_P_W-1:0] s3_q;
  reg  [`CMBI_P_W-1:0] p_q;
  wire [`CMBI_P_W-1:0] p_d = agree(s2_q, s3_q, p_q);

  // three-stage synchroniser on every host bus, control and port pin
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s1_q <= {`CMBI_P_W{1'b0}};
      s2_q <= {`CMBI_P_W{1'b0}};
      s3_q <= {`CMBI_P_W{1'b0}};
      p_q  <= {`CMBI_P_W{1'b0}};
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      p_q  <= p_d;
    end
  end

  // captured configuration
  reg        ld_q;
  reg        w16_q;
  reg        mux_q;
  reg        sty_q;
  reg        top_q;
  reg        alp_q;
  reg        rsp_q;
  reg        spl_q;
  reg        trk_q;
  reg [7:0]  paf_q;
  reg [7:0]  pbf_q;
  reg [2:0]  pcf_q;
  reg [7:0]  pad_q;
  reg [7:0]  pbd_q;
  reg        ual_q;
  reg        lck_q;

  // configuration is loaded once after reset release
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      ld_q  <= 1'b0;
      w16_q <= 1'b0;
      mux_q <= 1'b0;
      sty_q <= 1'b0;
      top_q <= 1'b0;
      alp_q <= 1'b0;
      rsp_q <= 1'b0;
      spl_q <= 1'b0;
      trk_q <= 1'b0;
      paf_q <= 8'h00;
      pbf_q <= 8'hff;
      pcf_q <= 3'h0;
      pad_q <= 8'h00;
      pbd_q <= 8'h00;
      ual_q <= 1'b0;
      lck_q <= 1'b1;
    end
    else if (!ld_q)
    begin
      ld_q  <= 1'b1;
      w16_q <= CFG_DATA_WIDTH_SEL;
      mux_q <= CFG_ADDR_DATA_MUX_SEL;
      sty_q <= CFG_STROBE_STYLE_SEL;
      top_q <= CFG_TOP_PIN_FUNCTION_SEL;
      alp_q <= CFG_LATCH_STROBE_POLARITY;
      rsp_q <= CFG_RESET_POLARITY_SEL;
      spl_q <= CFG_CODE_DATA_SPLIT_SEL;
      trk_q <= CFG_PORTA_TRACK_SEL;
      paf_q <= CFG_PORTA_BIT_FUNCTION;
      pbf_q <= CFG_PORTB_BIT_FUNCTION;
      pcf_q <= CFG_PORTC_BIT_FUNCTION;
      pad_q <= CFG_PORTA_DRIVER_TYPE;
      pbd_q <= CFG_PORTB_DRIVER_TYPE;
      ual_q <= CFG_UPPER_ADDR_LATCH_SEL;
      lck_q <= CFG_READBACK_LOCK;
    end
  end

  // decoded pin meaning under the captured configuration
  wire [15:0] hd_in  = p_q[`CMBI_P_HD+15:`CMBI_P_HD];
  wire [15:0] adr_in = p_q[`CMBI_P_ADR+15:`CMBI_P_ADR];
  wire [2:0]  pc_in  = p_q[`CMBI_P_PC+2:`CMBI_P_PC];
  wire        ale_on = p_q[`CMBI_P_ALE] ^ alp_q;
  wire        hrst   = ld_q & ~(p_q[`CMBI_P_RST] ^ rsp_q);
  wire        pdn    = ~top_q & p_q[`CMBI_P_TOP];
  wire        a19    = top_q & p_q[`CMBI_P_TOP];
  wire        program_store_enable   = ~p_q[`CMBI_P_PSENN];
  wire        rd_on  = sty_q ? (p_q[`CMBI_P_E] & p_q[`CMBI_P_RW])
                             : ~p_q[`CMBI_P_RDN];
  wire        wr_on  = sty_q ? (p_q[`CMBI_P_E] & ~p_q[`CMBI_P_RW])
                             : ~p_q[`CMBI_P_WRN];
  wire        act    = ld_q & ~pdn & ~hrst;

  reg  [15:0] alat_q;
  reg  [3:0]  ulat_q;
  reg         wr_q;
  reg  [15:0] wd_q;
  reg  [7:0]  pa_q;
  reg  [7:0]  pb_q;
  reg  [7:0]  pa_dir_q;
  reg  [7:0]  pb_dir_q;

  // upper address from port c inputs and the top pin
  wire [3:0]  up_pin = {a19, pc_in & ~pcf_q};
  wire [3:0]  up     = ual_q ? ulat_q : up_pin;
  wire [15:0] lo     = mux_q ? alat_q : adr_in;
  wire [19:0] a      = {up, lo};
  wire        io_hit = (a[19:2] == `CMBI_IO_BASE);
  wire [1:0]  ofs    = a[1:0];
  wire        wr_end = wr_q & ~wr_on;
  wire        code   = spl_q ? program_store_enable : ~a[15];

  // address latches capture while the latch strobe is active
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      alat_q <= 16'h0000;
      ulat_q <= 4'h0;
    end
    else if (ale_on)
    begin
      alat_q <= hd_in;
      ulat_q <= up_pin;
    end
  end

  // port registers, written at the end of a host write
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_q     <= 1'b0;
      wd_q     <= 16'h0000;
      pa_q     <= `CMBI_RST_DATA;
      pb_q     <= `CMBI_RST_DATA;
      pa_dir_q <= `CMBI_RST_DIR;
      pb_dir_q <= `CMBI_RST_DIR;
    end
    else if (hrst)
    begin
      wr_q     <= 1'b0;
      pa_dir_q <= `CMBI_RST_DIR;
      pb_dir_q <= `CMBI_RST_DIR;
    end
    else
    begin
      wr_q <= wr_on & act;
      if (wr_on)
        wd_q <= hd_in;
      if (wr_end && io_hit)
      begin
        // 16-bit writes fill a and b together from one word
        if (w16_q)
        begin
          if (ofs == `CMBI_OFS_PA)
          begin
            pa_q <= wd_q[7:0];
            pb_q <= wd_q[15:8];
          end
          if (ofs == `CMBI_OFS_PADIR)
          begin
            pa_dir_q <= wd_q[7:0];
            pb_dir_q <= wd_q[15:8];
          end
        end
        else
        begin
          case (ofs)
            `CMBI_OFS_PA:    pa_q     <= wd_q[7:0];
            `CMBI_OFS_PB:    pb_q     <= wd_q[7:0];
            `CMBI_OFS_PADIR: pa_dir_q <= wd_q[7:0];
            default:         pb_dir_q <= wd_q[7:0];
          endcase
        end
      end
    end
  end

  // decoder, asleep while powered down
  reg [10:0] cs_n;
  integer    k;
  always @*
  begin
    cs_n = `CMBI_RST_CS;
    for (k = 0; k < 10; k = k + 1)
      cs_n[k] = ~(act & hit(a, k[3:0]));
    // separate mode lets the latch strobe act as a plain input
    cs_n[10] = ~(act & (hit(a, `CMBI_CS_TOP) |
                 (~mux_q & p_q[`CMBI_P_ALE])));
  end

  // port a line selection: i/o, latched address or track
  wire [7:0] pa_val = trk_q ? hd_in[7:0] :
                      ((paf_q & alat_q[7:0]) | (~paf_q & pa_q));
  wire [7:0] pa_en  = trk_q ? 8'hff : (paf_q | pa_dir_q);
  // port b line selection: i/o where field bit set, select otherwise
  wire [7:0] pb_val = (pbf_q & pb_q) | (~pbf_q & cs_n[7:0]);
  wire [7:0] pb_en  = (pbf_q & pb_dir_q) | ~pbf_q;

  // read data: ports in the i/o window, memory elsewhere
  reg [15:0] rd_val;
  always @*
  begin
    rd_val = MEM_RDATA[15:0];
    if (io_hit)
    begin
      case (ofs)
        `CMBI_OFS_PA:    rd_val = {p_q[`CMBI_P_PB+7:`CMBI_P_PB],
                                   p_q[`CMBI_P_PA+7:`CMBI_P_PA]};
        `CMBI_OFS_PB:    rd_val = {8'h00, p_q[`CMBI_P_PB+7:`CMBI_P_PB]};
        `CMBI_OFS_PADIR: rd_val = {pb_dir_q, pa_dir_q};
        default:         rd_val = {8'h00, pb_dir_q};
      endcase
    end
  end

  // configuration readback for programming equipment
  reg [7:0] cfg_byte;
  always @*
  begin
    case (PROG_RD_SEL)
      2'h0:    cfg_byte = {w16_q, mux_q, sty_q, top_q,
                           alp_q, rsp_q, spl_q, trk_q};
      2'h1:    cfg_byte = paf_q;
      2'h2:    cfg_byte = pbf_q;
      default: cfg_byte = {3'h0, pcf_q, ual_q, lck_q};
    endcase
  end

  // registered outputs
  always @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      HD_O           <= {DW{1'b0}};
      HD_OE          <= 2'h0;
      PA_O           <= 8'h00;
      PA_OE          <= 8'h00;
      PB_O           <= 8'h00;
      PB_OE          <= 8'h00;
      PC_O           <= 3'h7;
      PC_OE          <= 3'h0;
      MEM_ADDR       <= 20'h00000;
      MEM_CODE_SEL   <= 1'b0;
      MEM_DATA_SEL   <= 1'b0;
      MEM_RD         <= 1'b0;
      MEM_WR         <= 1'b0;
      MEM_WDATA      <= {DW{1'b0}};
      POWER_DOWN     <= 1'b0;
      PROG_RD_DATA   <= 8'h00;
      PROG_RD_DENIED <= 1'b0;
    end
    else
    begin
      HD_O  <= rd_val[DW-1:0];
      HD_OE <= {2{act & rd_on}} & {w16_q, 1'b1};
      PA_O  <= pa_val;
      PA_OE <= hrst ? 8'h00 : drv_en(pa_en, pa_val, pad_q);
      PB_O  <= pb_val;
      PB_OE <= hrst ? 8'h00 : drv_en(pb_en, pb_val, pbd_q);
      PC_O  <= cs_n[10:8] | ~pcf_q;
      PC_OE <= hrst ? 3'h0 : pcf_q;
      MEM_ADDR     <= a;
      MEM_CODE_SEL <= act & ~io_hit & code;
      MEM_DATA_SEL <= act & ~io_hit & ~code;
      MEM_RD       <= act & ~io_hit & (rd_on | (spl_q & program_store_enable));
      MEM_WR       <= act & ~io_hit & wr_on;
      MEM_WDATA    <= hd_in[DW-1:0];
      POWER_DOWN   <= ld_q & pdn;
      if (PROG_RD_REQ)
      begin
        PROG_RD_DATA   <= lck_q ? 8'h00 : cfg_byte;
        PROG_RD_DENIED <= lck_q;
      end
    end
  end

endmodule

// >>> cmbi_map.vh
// constants of the configurable host bus front end
`ifndef CMBI_MAP_VH
`define CMBI_MAP_VH
// host i/o window, address bits 19:2
`define CMBI_IO_BASE   18'h3fffc
// port register offsets inside the window
`define CMBI_OFS_PA    2'h0
`define CMBI_OFS_PB    2'h1
`define CMBI_OFS_PADIR 2'h2
`define CMBI_OFS_PBDIR 2'h3
// reset values
`define CMBI_RST_DIR   8'h00
`define CMBI_RST_DATA  8'h00
`define CMBI_RST_CS    11'h7ff
// field positions in the synchronised pin vector
`define CMBI_P_RDN     0
`define CMBI_P_WRN     1
`define CMBI_P_RW      2
`define CMBI_P_E       3
`define CMBI_P_ALE     4
`define CMBI_P_PSENN   5
`define CMBI_P_RST     6
`define CMBI_P_TOP     7
`define CMBI_P_PC      8
`define CMBI_P_ADR     11
`define CMBI_P_HD      27
`define CMBI_P_PA      43
`define CMBI_P_PB      51
`define CMBI_P_W       59
// chip-select index driven on the top port c line
`define CMBI_CS_TOP    4'ha
`endif

// >>> cmbi_chk.sv
// assertion checker for the host bus front end
`timescale 1ns/10ps
module cmbi_chk (
  input wire       CLK,
  input wire       RSTN,
  input wire       CFG_DATA_WIDTH_SEL,
  input wire       CFG_STROBE_STYLE_SEL,
  input wire       CFG_TOP_PIN_FUNCTION_SEL,
  input wire       CFG_RESET_POLARITY_SEL,
  input wire [7:0] CFG_PORTB_BIT_FUNCTION,
  input wire [2:0] CFG_PORTC_BIT_FUNCTION,
  input wire [7:0] CFG_PORTB_DRIVER_TYPE,
  input wire       CFG_READBACK_LOCK,
  input wire       HOST_RESET,
  input wire       RD_N,
  input wire       TOP_PIN,
  input wire [1:0] HD_OE,
  input wire [7:0] PA_OE,
  input wire [7:0] PB_O,
  input wire [7:0] PB_OE,
  input wire [2:0] PC_OE,
  input wire       POWER_DOWN,
  input wire       PROG_RD_REQ,
  input wire [7:0] PROG_RD_DATA,
  input wire       PROG_RD_DENIED
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // relations between configuration, pins and outputs
  property p_width;
    !CFG_DATA_WIDTH_SEL |-> HD_OE[1] == 1'b0;
  endproperty
  a_width: assert property (p_width) else $error("upper byte driven");
  property p_idle;
    (!CFG_STROBE_STYLE_SEL && RD_N)[*8] |-> HD_OE == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("data driven without read");
  property p_pd_on;
    (!CFG_TOP_PIN_FUNCTION_SEL && TOP_PIN)[*8] |-> POWER_DOWN;
  endproperty
  a_pd_on: assert property (p_pd_on) else $error("no standby");
  property p_pd_cs;
    POWER_DOWN[*2] |-> (PB_O | CFG_PORTB_BIT_FUNCTION) == 8'hff;
  endproperty
  a_pd_cs: assert property (p_pd_cs) else $error("select active in standby");
  property p_pb_od;
    (PB_OE & PB_O & CFG_PORTB_DRIVER_TYPE) == 8'h00;
  endproperty
  a_pb_od: assert property (p_pb_od) else $error("open drain drives high");
  property p_lock;
    PROG_RD_REQ && CFG_READBACK_LOCK |=> PROG_RD_DENIED && PROG_RD_DATA == 8'h00;
  endproperty
  a_lock: assert property (p_lock) else $error("locked readback answered");
  property p_hrst;
    (HOST_RESET == CFG_RESET_POLARITY_SEL)[*8] |-> {PA_OE, PB_OE, PC_OE} == 19'h00000;
  endproperty
  a_hrst: assert property (p_hrst) else $error("port driven in host reset");
  property p_pc_in;
    CFG_PORTC_BIT_FUNCTION == 3'h0 |-> PC_OE == 3'h0;
  endproperty
  a_pc_in: assert property (p_pc_in) else $error("port c driven as input");
endmodule

bind cmbi_top cmbi_chk i_cmbi_chk (.*);

// >>> cmbi_host.sv
// behavioural host bus master for the front end
`timescale 1ns/10ps
module cmbi_host (
  input  wire        CLK,
  input  wire [1:0]  HD_OE,
  output reg         RD_N,
  output reg         WR_N,
  output reg         TOP_PIN,
  output reg  [2:0]  PC_I,
  output reg  [15:0] ADDR_I,
  output reg  [15:0] HD_I,
  output reg         GOT
);
  // idle bus with every address line driven
  initial
  begin
    {RD_N, WR_N, GOT} = 3'h6;
    {TOP_PIN, PC_I, ADDR_I} = 20'h00000;
    HD_I = 16'h5aa5;
  end
  // drive the address lines only
  task put(input [19:0] a);
  begin
    @(posedge CLK);
    {TOP_PIN, PC_I, ADDR_I} <= a;
  end
  endtask
  // one strobed access; ok drops when a read gets no answer
  task acc(input [19:0] a, input rd, input [7:0] d, output ok);
    integer n;
  begin
    put(a);
    HD_I <= {~d, d};
    repeat (6) @(posedge CLK);
    if (rd)
      RD_N <= 1'b0;
    else
      WR_N <= 1'b0;
    repeat (6) @(posedge CLK);
    n = 0;
    while (rd && HD_OE[0] !== 1'b1 && n < 20)
    begin
      @(posedge CLK);
      n = n + 1;
    end
    ok = (n < 20);
    GOT <= rd;
    @(posedge CLK);
    {GOT, RD_N, WR_N} <= 3'h3;
    HD_I <= {d, ~d}; // released bus shows the inverse
    repeat (7) @(posedge CLK);
  end
  endtask
endmodule

// >>> tb_cmbi_top.sv
// self-checking bench for the host bus front end
`timescale 1ns/10ps
module tb_cmbi_top;
  reg         CLK = 1'b0, RSTN = 1'b0, HOST_RESET, PROG_RD_REQ = 1'b0, look = 1'b0;
  reg         RW = 1'b1, E = 1'b0, ALE = 1'b0, PROGRAM_STORE_ENABLE_N = 1'b1;
  reg         CFG_DATA_WIDTH_SEL, CFG_ADDR_DATA_MUX_SEL, CFG_STROBE_STYLE_SEL;
  reg         CFG_LATCH_STROBE_POLARITY, CFG_CODE_DATA_SPLIT_SEL, CFG_PORTA_TRACK_SEL;
  reg         CFG_UPPER_ADDR_LATCH_SEL, CFG_READBACK_LOCK;
  reg         CFG_TOP_PIN_FUNCTION_SEL, CFG_RESET_POLARITY_SEL;
  reg  [7:0]  CFG_PORTA_BIT_FUNCTION, CFG_PORTB_BIT_FUNCTION;
  reg  [7:0]  CFG_PORTA_DRIVER_TYPE, CFG_PORTB_DRIVER_TYPE;
  reg  [2:0]  CFG_PORTC_BIT_FUNCTION;
  reg  [7:0]  PA_I = 8'h00, PB_I = 8'h00, rnd = 8'h5d;
  reg  [1:0]  PROG_RD_SEL = 2'h0;
  reg  [15:0] MEM_RDATA = 16'h0000;
  wire [15:0] ADDR_I, HD_I, HD_O, MEM_WDATA;
  wire [7:0]  PA_O, PA_OE, PB_O, PB_OE, PROG_RD_DATA;
  wire [2:0]  PC_I, PC_O, PC_OE;
  wire [1:0]  HD_OE;
  wire [19:0] MEM_ADDR;
  wire        RD_N, WR_N, TOP_PIN, GOT, MEM_CODE_SEL, MEM_DATA_SEL, MEM_RD, MEM_WR;
  wire        POWER_DOWN, PROG_RD_DENIED;
  wire [51:0] obs = {PROG_RD_DENIED, MEM_DATA_SEL, MEM_CODE_SEL, PC_O,
                     HD_OE, HD_O[7:0], POWER_DOWN, PC_OE, PB_OE, PB_O, PA_OE, PA_O};
  logic [103:0] q[$];
  logic [103:0] t;
  reg         io;
  string      nq[$];
  integer     fail_count = 0, checked = 0, k;
  reg         ok;

  cmbi_top i_cmbi_top (.*);
  cmbi_host i_cmbi_host (.*);

  always #2.5 CLK = ~CLK;

  // compare one observed value with its expectation
  task chk(input string nm, input logic [51:0] e, input logic [51:0] s);
  begin
    checked = checked + 1;
    if (s !== e)
    begin
      fail_count = fail_count + 1;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  end
  endtask
  // byte placed at a bit position of the observation vector
  function [51:0] f(input integer p, input [7:0] v);
    f = {44'h0, v} << p;
  endfunction
  // queue one masked expectation
  task note(input string nm, input integer p, input [7:0] m, input [7:0] e);
  begin
    q.push_back({f(p, m), f(p, e)});
    nq.push_back(nm);
  end
  endtask
  // let the watcher take the queued notes
  task show;
  begin
    look <= 1'b1;
    @(posedge CLK);
    look <= 1'b0;
    @(posedge CLK);
  end
  endtask
  // pseudo random byte sequence
  function [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // watcher: every queued note against the outputs when a result shows
  always @(posedge CLK)
    if (look || GOT)
      while (q.size() > 0)
      begin
        t = q.pop_front();
        chk(nq.pop_front(), t[51:0], obs & t[103:52]);
      end
  // report and end the run
  task close_out;
  begin
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  // reset with one of two configurations
  task run_cfg(input r2);
  begin
    RSTN <= 1'b0;
    {CFG_DATA_WIDTH_SEL, CFG_ADDR_DATA_MUX_SEL, CFG_STROBE_STYLE_SEL} <= {3{r2}};
    {CFG_LATCH_STROBE_POLARITY, CFG_CODE_DATA_SPLIT_SEL, CFG_PORTA_TRACK_SEL} <= {3{r2}};
    CFG_UPPER_ADDR_LATCH_SEL <= r2;
    {CFG_TOP_PIN_FUNCTION_SEL, CFG_READBACK_LOCK, HOST_RESET} <= {3{!r2}};
    CFG_RESET_POLARITY_SEL <= r2;
    {CFG_PORTA_BIT_FUNCTION, CFG_PORTB_BIT_FUNCTION, CFG_PORTA_DRIVER_TYPE} <= 24'h000000;
    CFG_PORTB_DRIVER_TYPE <= r2 ? 8'h00 : 8'hc0;
    CFG_PORTC_BIT_FUNCTION <= r2 ? 3'h7 : 3'h0;
    repeat (10) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (8) @(posedge CLK);
  end
  endtask

  // main sequence
  initial
  begin
    run_cfg(1'b0);
    note("pa_oe", 8, 8'hff, 8'h00);
    PROG_RD_REQ <= 1'b1;
    show;
    PROG_RD_REQ <= 1'b0;
    note("denied", 51, 8'h01, 8'h01);
    for (k = 0; k < 16; k = k + 1)
    begin
      rnd = lfsr(rnd);
      {PA_I, PB_I, MEM_RDATA, PROG_RD_SEL} <= {rnd, ~rnd, rnd, rnd, rnd[1:0]};
      i_cmbi_host.put({k[3:0], rnd, rnd});
      repeat (8) @(posedge CLK);
      note("cs_b", 16, 8'h3f, ~(8'h01 << k) & 8'h3f);
      note("oe_b", 24, 8'hff, 8'h3f | (8'hc0 & (8'h01 << k)));
      note("oe_c", 32, 8'h07, 8'h00);
      note("pd", 35, 8'h01, 8'h00);
      // combined space: address bit 15 low is code, the i/o window is neither
      io = (k == 15) && (rnd == 8'hff);
      note("mem_sel", 49, 8'h03, io ? 8'h00 : (rnd[7] ? 8'h02 : 8'h01));
      show;
    end
    i_cmbi_host.acc(20'hffff2, 1'b0, 8'hff, ok);
    i_cmbi_host.acc(20'hffff0, 1'b0, rnd, ok);
    note("pa_o", 0, 8'hff, rnd);
    note("pa_oe", 8, 8'hff, 8'hff);
    show;
    note("rd_dir", 36, 8'hff, 8'hff);
    note("rd_oe", 44, 8'h03, 8'h01);
    i_cmbi_host.acc(20'hffff2, 1'b1, 8'h00, ok);
    if (!ok)
    begin
      fail_count = fail_count + 1;
      close_out;
    end
    HOST_RESET <= 1'b0;
    repeat (10) @(posedge CLK);
    note("pa_oe_hr", 8, 8'hff, 8'h00);
    show;
    HOST_RESET <= 1'b1;
    repeat (8) @(posedge CLK);
    note("pa_oe_dir", 8, 8'hff, 8'h00);
    show;
    run_cfg(1'b1);
    i_cmbi_host.put(20'h80000);
    repeat (10) @(posedge CLK);
    note("pd_on", 35, 8'h01, 8'h01);
    note("cs_pd", 16, 8'hff, 8'hff);
    note("oe_c", 32, 8'h07, 8'h07);
    note("cs_c_pd", 46, 8'h07, 8'h07);
    show;
    i_cmbi_host.put(20'h00000);
    repeat (10) @(posedge CLK);
    note("pd_off", 35, 8'h01, 8'h00);
    note("mem_sel_sp", 49, 8'h03, 8'h02);
    show;
    close_out;
  end
endmodule
